// ===== src/tcf_timer.sv
// 8-bit timer/counter with compare channels, flags and register port
//
// The address-and-strobe port was decided locally.
module tcf_timer (
  // clock, reset, enable
  input  wire logic                  clk_sys,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // register port
  input  wire tcf_pkg::tcf_bus_req_t bus_req,
  output logic [7:0]                 rd_data,
  // processor interrupt side: a, b, wrap
  input  wire logic                  cpu_irq_enable,
  input  wire logic [2:0]            vector_ack,
  output logic [2:0]                 irq_req,
  // pins
  input  wire logic                  ext_count_pin,
  output logic [1:0]                 wave_out,
  output logic [1:0]                 wave_oe
);
  import tcf_pkg::*;

  tcf_state_t  s_q;        // registered state
  tcf_state_t  s_d;        // next state
  logic [2:0]  mode;       // waveform mode
  logic        is_fast;    // fast pwm
  logic        is_phase;   // phase correct pwm
  logic        is_pwm;     // any pwm mode
  logic        top_cmp;    // top taken from compare a
  logic [7:0]  top;        // top value
  logic        ext_rise;   // pin rising edge pulse
  logic        ext_fall;   // pin falling edge pulse
  logic        tick;       // count enable this cycle
  logic        wr_ctrl_a;  // register write decodes
  logic        wr_ctrl_b;
  logic        wr_cnt;
  logic        wr_mask;
  logic        wr_flags;
  logic        at_top;     // counter sits at top
  logic        bottom_ev;  // fast pwm wraps to bottom
  logic        wrap_set;   // overflow event
  logic [1:0]  hit;        // real compare match per channel
  logic [1:0]  force_hit;  // forced match per channel
  logic [1:0]  wave_nx;    // next waveform level
  logic [1:0][1:0] act;    // output action per channel

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // spread a, b, wrap bits onto their register positions
  function automatic logic [7:0] irq_pack(input logic [2:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 3; i++)
    begin
      r[IRQ_POS[i]] = v[i];
    end
    return r;
  endfunction

  // gather a, b, wrap bits from their register positions
  function automatic logic [2:0] irq_unpack(input logic [7:0] r);
    logic [2:0] v;
    v = '0;
    for (int i = 0; i < 3; i++)
    begin
      v[i] = r[IRQ_POS[i]];
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // external pin edges, counted regardless of pin direction
  tcf_edge_detect u_edge (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .clk_en     (clk_en),
    .pin_in     (ext_count_pin),
    .rise_pulse (ext_rise),
    .fall_pulse (ext_fall)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode decode
  assign mode     = {s_q.wgm_hi, s_q.ctrl_a[WGM_LO_POS +: 2]};
  assign is_fast  = (mode == MODE_FAST_FF) || (mode == MODE_FAST_CMP);
  assign is_phase = (mode == MODE_PC_FF) || (mode == MODE_PC_CMP);
  assign is_pwm   = is_fast || is_phase;
  assign top_cmp  = (mode == MODE_CTC) || (mode == MODE_PC_CMP) ||
                    (mode == MODE_FAST_CMP);
  assign top      = top_cmp ? s_q.cmp[IDX_A] : CNT_MAX;
  assign at_top   = (s_q.count == top);

  // count enable from the selected source
  always_comb
  begin
    case (s_q.clk_sel)
      CS_STOP:     tick = 1'b0;
      CS_DIV1:     tick = 1'b1;
      CS_DIV8:     tick = (s_q.presc & PRE_MASK_8) == PRE_MASK_8;
      CS_DIV64:    tick = (s_q.presc & PRE_MASK_64) == PRE_MASK_64;
      CS_DIV256:   tick = (s_q.presc & PRE_MASK_256) == PRE_MASK_256;
      CS_DIV1024:  tick = (s_q.presc & PRE_MASK_1024) == PRE_MASK_1024;
      CS_EXT_FALL: tick = ext_fall;
      CS_EXT_RISE: tick = ext_rise;
      default:     tick = 1'b0;
    endcase
  end

  // register write decode
  assign wr_ctrl_a = bus_req.we && (bus_req.addr == OFF_CTRL_A);
  assign wr_ctrl_b = bus_req.we && (bus_req.addr == OFF_CTRL_B);
  assign wr_cnt    = bus_req.we && (bus_req.addr == OFF_COUNT);
  assign wr_mask   = bus_req.we && (bus_req.addr == OFF_MASK);
  assign wr_flags  = bus_req.we && (bus_req.addr == OFF_FLAGS);

  // overflow point per mode
  assign bottom_ev = tick && is_fast && at_top;
  always_comb
  begin
    if (is_phase)
      wrap_set = tick && (s_q.dir == DIR_DOWN) &&
                 (s_q.count == CNT_BOTTOM);
    else if (is_fast)
      wrap_set = tick && at_top;
    else
      wrap_set = tick && (s_q.count == CNT_MAX);
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-channel compare and waveform
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    assign act[i] = s_q.ctrl_a[ACT_POS[i] +: 2];
    // match only on a tick not blocked by a counter write
    assign hit[i] = tick && !s_q.block &&
                    (s_q.count == s_q.cmp[i]);
    // strobe acts only outside pwm; in pwm it is dropped
    assign force_hit[i] = wr_ctrl_b && bus_req.wdata[FORCE_POS[i]] &&
                          !is_pwm;
    assign wave_nx[i] = wave_next(s_q.wave[i], act[i], hit[i],
                                  force_hit[i], is_pwm, is_fast,
                                  s_q.dir == DIR_DOWN, bottom_ev,
                                  s_q.cmp[i] == top);
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    s_d = s_q;
    s_d.presc = s_q.presc + 10'h001;

    // configuration writes
    if (wr_ctrl_a)
      s_d.ctrl_a = bus_req.wdata & CTRL_A_WMASK;
    if (wr_ctrl_b)
    begin
      s_d.wgm_hi  = bus_req.wdata[WGM_HI_POS];
      s_d.clk_sel = bus_req.wdata[CS_POS +: 3];
    end
    if (bus_req.we && (bus_req.addr == OFF_CMP_A))
      s_d.cmp[IDX_A] = bus_req.wdata;
    if (bus_req.we && (bus_req.addr == OFF_CMP_B))
      s_d.cmp[IDX_B] = bus_req.wdata;
    if (wr_mask)
      s_d.mask = irq_unpack(bus_req.wdata);

    // counting; forced matches never reach this path
    if (tick)
    begin
      s_d.block = 1'b0;
      if (is_phase)
      begin
        case (s_q.dir)
          DIR_UP:
          begin
            if (at_top)
            begin
              s_d.dir   = DIR_DOWN;
              s_d.count = s_q.count - CNT_ONE;
            end
            else
              s_d.count = s_q.count + CNT_ONE;
          end
          DIR_DOWN:
          begin
            if (s_q.count == CNT_BOTTOM)
            begin
              s_d.dir   = DIR_UP;
              s_d.count = s_q.count + CNT_ONE;
            end
            else
              s_d.count = s_q.count - CNT_ONE;
          end
          default:
          begin
            s_d.dir = DIR_UP;
          end
        endcase
      end
      else if (top_cmp || is_fast)
      begin
        // clear on reaching top, match block or not; a forced match cannot do it
        s_d.dir   = DIR_UP;
        s_d.count = at_top ? CNT_BOTTOM : s_q.count + CNT_ONE;
      end
      else
      begin
        s_d.dir   = DIR_UP;
        s_d.count = s_q.count + CNT_ONE;
      end
    end

    // software write wins over a tick and arms the match block
    if (wr_cnt)
    begin
      s_d.count = bus_req.wdata;
      s_d.block = 1'b1;
    end

    // flags: events set, vector ack and write-one clear; set wins
    s_d.flags = s_q.flags & ~vector_ack;
    if (wr_flags)
      s_d.flags = s_d.flags & ~irq_unpack(bus_req.wdata);
    s_d.flags[IDX_A]    = s_d.flags[IDX_A] | hit[IDX_A];
    s_d.flags[IDX_B]    = s_d.flags[IDX_B] | hit[IDX_B];
    s_d.flags[IDX_WRAP] = s_d.flags[IDX_WRAP] | wrap_set;

    // requests need enable, global enable and flag
    s_d.irq = s_q.mask & s_q.flags & {3{cpu_irq_enable}};

    // waveform and pin override
    s_d.wave = wave_nx;
    s_d.oe   = {|s_d.ctrl_a[ACT_POS[IDX_B] +: 2],
                |s_d.ctrl_a[ACT_POS[IDX_A] +: 2]};

    // read data stand for exactly one cycle after the strobe
    s_d.rdata = 8'h00;
    if (bus_req.re)
    begin
      case (bus_req.addr)
        OFF_CTRL_A: s_d.rdata = s_q.ctrl_a;
        // force bits and bits 5:4 read zero
        OFF_CTRL_B: s_d.rdata = {4'h0, s_q.wgm_hi,
                                 s_q.clk_sel};
        OFF_COUNT:  s_d.rdata = s_q.count;
        OFF_CMP_A:  s_d.rdata = s_q.cmp[IDX_A];
        OFF_CMP_B:  s_d.rdata = s_q.cmp[IDX_B];
        OFF_MASK:   s_d.rdata = irq_pack(s_q.mask);
        OFF_FLAGS:  s_d.rdata = irq_pack(s_q.flags);
        default:    s_d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register, frozen while the enable is low
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_q <= TCF_STATE_RST;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from state
  assign rd_data  = s_q.rdata;
  assign irq_req  = s_q.irq;
  assign wave_out = s_q.wave;
  assign wave_oe  = s_q.oe;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);

  sequence s_cnt_write;
    clk_en && wr_cnt;
  endsequence

  sequence s_cnt_read;
    clk_en && bus_req.re && (bus_req.addr == OFF_COUNT);
  endsequence

  a_force_toggle:
  assert property (clk_en && force_hit[IDX_A] && !hit[IDX_A] &&
                   act[IDX_A] == ACT_TOGGLE
                   |=> wave_out[IDX_A] != $past(wave_out[IDX_A]))
    else $error("forced toggle did not change output a");

  a_force_no_flag:
  assert property (clk_en && force_hit[IDX_B] && !hit[IDX_B]
                   |=> s_q.flags[IDX_B] ==
                       $past(s_q.flags[IDX_B] & ~vector_ack[IDX_B]))
    else $error("forced match changed flag b");

  a_force_reads_zero:
  assert property (clk_en && bus_req.re && bus_req.addr == OFF_CTRL_B
                   |=> rd_data[7:6] == 2'h0)
    else $error("force bits read nonzero");

  a_reserved_zero:
  assert property (clk_en && bus_req.re &&
                   (bus_req.addr == OFF_MASK || bus_req.addr == OFF_FLAGS)
                   |=> rd_data[7] == 1'b0 && rd_data[0] == 1'b0)
    else $error("reserved mask or flag bit read nonzero");

  a_stop_holds:
  assert property (clk_en && s_q.clk_sel == CS_STOP && !wr_cnt
                   |=> $stable(s_q.count))
    else $error("stopped counter moved");

  a_count_rw:
  assert property (s_cnt_write ##1 s_cnt_read
                   |=> rd_data == $past(bus_req.wdata, 2))
    else $error("counter read differs from value written");

  a_write_blocks:
  assert property (s_cnt_write
                   |=> s_q.block && hit == 2'b00)
    else $error("match not blocked after counter write");

  a_irq_gate:
  assert property (clk_en
                   |=> irq_req == $past(s_q.mask & s_q.flags &
                                        {3{cpu_irq_enable}}))
    else $error("interrupt request not gated by enables");

  a_match_flag:
  assert property (clk_en && hit[IDX_A] |=> s_q.flags[IDX_A])
    else $error("match a did not set its flag");

  a_flag_w1c:
  assert property (clk_en && wr_flags && bus_req.wdata[IRQ_POS[IDX_A]] &&
                   !hit[IDX_A] |=> !s_q.flags[IDX_A])
    else $error("write one did not clear flag a");

  a_wrap_normal:
  assert property (clk_en && tick && mode == MODE_NORMAL && !wr_cnt &&
                   s_q.count == CNT_MAX
                   |=> s_q.flags[IDX_WRAP] && s_q.count == CNT_BOTTOM)
    else $error("normal mode overflow missed");

endmodule

// ===== include/tcf_pkg.sv
// package of constants, encodings, types and waveform helper for the timer
package tcf_pkg;

  //////////////////////////////////////////////////////////////////////////
  // register offsets on the plain register port
  localparam logic [7:0] OFF_CTRL_A  = 8'h30;  // output actions, low mode bits
  localparam logic [7:0] OFF_CTRL_B  = 8'h33;  // force strobes, clock select
  localparam logic [7:0] OFF_COUNT   = 8'h32;  // counter value
  localparam logic [7:0] OFF_CMP_A   = 8'h29;  // compare value a
  localparam logic [7:0] OFF_CMP_B   = 8'h28;  // compare value b
  localparam logic [7:0] OFF_MASK    = 8'h39;  // interrupt enables
  localparam logic [7:0] OFF_FLAGS   = 8'h38;  // interrupt flags

  //////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int FORCE_POS [2]   = '{7, 6};  // force strobes in ctrl b
  localparam int ACT_POS [2]     = '{6, 4};  // output action fields, ctrl a
  localparam int WGM_LO_POS      = 0;        // low mode bits in ctrl a
  localparam int WGM_HI_POS      = 3;        // high mode bit in ctrl b
  localparam int CS_POS          = 0;        // clock select in ctrl b
  localparam int IRQ_POS [3]     = '{4, 3, 1};  // a, b, wrap in mask/flags
  localparam logic [7:0] CTRL_A_WMASK = 8'hF3;  // bits 3:2 read as zero

  // channel / event index in 3-bit mask and flag vectors
  localparam int IDX_A    = 0;
  localparam int IDX_B    = 1;
  localparam int IDX_WRAP = 2;

  //////////////////////////////////////////////////////////////////////////
  // clock select codes
  localparam logic [2:0] CS_STOP     = 3'h0;
  localparam logic [2:0] CS_DIV1     = 3'h1;
  localparam logic [2:0] CS_DIV8     = 3'h2;
  localparam logic [2:0] CS_DIV64    = 3'h3;
  localparam logic [2:0] CS_DIV256   = 3'h4;
  localparam logic [2:0] CS_DIV1024  = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;

  // prescaler taps: tick when the low bits of the divider are all ones
  localparam logic [9:0] PRE_MASK_8    = 10'h007;  // divide by 8
  localparam logic [9:0] PRE_MASK_64   = 10'h03F;  // divide by 64
  localparam logic [9:0] PRE_MASK_256  = 10'h0FF;  // divide by 256
  localparam logic [9:0] PRE_MASK_1024 = 10'h3FF;  // divide by 1024

  //////////////////////////////////////////////////////////////////////////
  // waveform modes, output actions, fixed counter values
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_PC_FF    = 3'h1;
  localparam logic [2:0] MODE_CTC      = 3'h2;
  localparam logic [2:0] MODE_FAST_FF  = 3'h3;
  localparam logic [2:0] MODE_PC_CMP   = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;

  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;

  localparam logic [7:0] CNT_MAX    = 8'hFF;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_ONE    = 8'h01;

  //////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } tcf_dir_t;

  typedef struct packed {
    logic       we;     // write strobe
    logic       re;     // read strobe
    logic [7:0] addr;   // register offset
    logic [7:0] wdata;  // write data
  } tcf_bus_req_t;

  typedef struct packed {
    logic [7:0]      ctrl_a;   // output actions and low mode bits
    logic            wgm_hi;   // high mode bit
    logic [2:0]      clk_sel;  // count clock select
    logic [7:0]      count;    // counter
    logic [1:0][7:0] cmp;      // compare values a, b
    logic [2:0]      mask;     // a, b, wrap enables
    logic [2:0]      flags;    // a, b, wrap flags
    tcf_dir_t        dir;      // phase correct direction
    logic            block;    // match blocked after counter write
    logic [9:0]      presc;    // free prescaler
    logic [1:0]      wave;     // waveform levels
    logic [1:0]      oe;       // waveform drives its pin
    logic [2:0]      irq;      // interrupt requests
    logic [7:0]      rdata;    // read data
  } tcf_state_t;

  localparam tcf_state_t TCF_STATE_RST = '{dir: DIR_UP, default: '0};

  typedef struct packed {
    logic sync1;  // first synchroniser stage
    logic sync2;  // second synchroniser stage
    logic prev;   // delayed copy for edge detect
  } tcf_edge_t;

  localparam tcf_edge_t TCF_EDGE_RST = '{default: '0};

  //////////////////////////////////////////////////////////////////////////
  // next waveform level for one channel
  function automatic logic wave_next(
    input logic       cur,
    input logic [1:0] a,
    input logic       m,
    input logic       f,
    input logic       pwm,
    input logic       fast,
    input logic       down,
    input logic       bot,
    input logic       cmp_is_top
  );
    logic w;
    w = cur;
    if (!pwm)
    begin
      // non-pwm: match or forced match applies the action
      if (m || f)
      begin
        case (a)
          ACT_TOGGLE: w = ~cur;
          ACT_CLEAR:  w = 1'b0;
          ACT_SET:    w = 1'b1;
          default:    w = cur;
        endcase
      end
    end
    else if (fast)
    begin
      // fast pwm: match sets level, bottom restores; value at top is
      // ignored on match so the output stays constant
      if (a[1] && m && !cmp_is_top)
        w = a[0];
      else if (a[1] && bot)
        w = ~a[0];
    end
    else if (a[1] && m)
    begin
      // phase correct: level depends on count direction
      w = a[0] ^ down;
    end
    return w;
  endfunction

endpackage

// ===== src/tcf_edge_detect.sv
// synchroniser and edge detector for the external count pin
module tcf_edge_detect (
  // clock, reset, enable
  input  wire logic clk_sys,
  input  wire logic reset,
  input  wire logic clk_en,
  // pin and edge pulses
  input  wire logic pin_in,
  output logic      rise_pulse,
  output logic      fall_pulse
);
  import tcf_pkg::*;

  tcf_edge_t s_q;  // registered state
  tcf_edge_t s_d;  // next state

  ////////////////////////////////////////////////////////////////////////////
  // shift the pin through two stages, the second feeds the edge compare
  always_comb
  begin
    s_d       = s_q;
    s_d.sync1 = pin_in;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
  end

  // one-cycle pulses, only the settled stage is looked at
  assign rise_pulse = s_q.sync2 & ~s_q.prev;
  assign fall_pulse = ~s_q.sync2 & s_q.prev;

  ////////////////////////////////////////////////////////////////////////////
  // state register, frozen while the enable is low
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_q <= TCF_EDGE_RST;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

endmodule

// ===== bench/tb.sv
// self-checking register-level bench for the timer block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD t=%0t got %h exp %h", $time, (g), (e)); end end

module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tcf_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // stimulus and observed signals
  logic         clk_sys;         // 50 MHz system clock
  logic         reset;           // synchronous, active high
  logic         clk_en;          // high except in the freeze check
  tcf_bus_req_t bus_req;         // register port request
  logic [7:0]   rd_data;         // read data, cycle after the strobe
  logic         cpu_irq_enable;  // global interrupt enable
  logic [2:0]   vector_ack;      // handler entry pulses a, b, wrap
  logic [2:0]   irq_req;         // interrupt requests a, b, wrap
  logic         ext_count_pin;   // external count input
  logic [1:0]   wave_out;        // waveform levels b, a
  logic [1:0]   wave_oe;         // waveform owns its pin
  int           n_fail;          // mismatches seen
  int           check_count;     // comparisons made
  // prescaler ratios for clock select codes 1 to 5
  int           div [5]  = '{1, 8, 64, 256, 1024};
  // every mapped offset plus one unmapped place
  logic [7:0]   offs [8] = '{OFF_CTRL_A, OFF_CTRL_B, OFF_COUNT, OFF_CMP_A,
                             OFF_CMP_B, OFF_MASK, OFF_FLAGS, 8'h00};

  tcf_timer i_tcf_timer (
    .clk_sys        (clk_sys),
    .reset          (reset),
    .clk_en         (clk_en),
    .bus_req        (bus_req),
    .rd_data        (rd_data),
    .cpu_irq_enable (cpu_irq_enable),
    .vector_ack     (vector_ack),
    .irq_req        (irq_req),
    .ext_count_pin  (ext_count_pin),
    .wave_out       (wave_out),
    .wave_oe        (wave_oe)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register port tasks: one-cycle strobe, then one idle cycle so that
  // no request signal is assigned twice in one time step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
  endtask

  // read data is looked at just after the edge that took the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    `CHK(rd_data, e)
    @(posedge clk_sys);
  endtask

  // verdict and end of run, also reached by the watchdog
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // clock and watchdog
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    reset          = 1'b1;
    clk_en         = 1'b1;
    bus_req        = '0;
    cpu_irq_enable = 1'b1;
    vector_ack     = 3'h0;
    ext_count_pin  = 1'b0;
    n_fail         = 0;
    check_count    = 0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(negedge clk_sys);
    // everything clears at reset, unmapped place reads zero
    `CHK({irq_req, wave_out, wave_oe}, 7'h00)
    @(posedge clk_sys);
    foreach (offs[i]) rd(offs[i], 8'h00);
    // reserved and strobe bits read back as zero
    wr(OFF_CTRL_B, 8'hF8);
    rd(OFF_CTRL_B, 8'h08);
    wr(OFF_CTRL_B, 8'h00);
    wr(OFF_MASK, 8'hFF);
    rd(OFF_MASK, 8'h1A);
    wr(OFF_FLAGS, 8'hFF);
    rd(OFF_FLAGS, 8'h00);
    // forced match in clear-on-match mode: pins move, no flag, no clear
    wr(OFF_CMP_A, 8'h40);
    wr(OFF_COUNT, 8'h40);
    wr(OFF_CTRL_A, 8'h72);
    rd(OFF_CTRL_A, 8'h72);
    `CHK(wave_oe, 2'b11)
    wr(OFF_CTRL_B, 8'hC0);
    `CHK(wave_out, 2'b11)
    wr(OFF_CTRL_B, 8'h80);
    `CHK(wave_out, 2'b10)
    rd(OFF_COUNT, 8'h40);
    rd(OFF_FLAGS, 8'h00);
    `CHK(irq_req, 3'b000)
    rd(OFF_CTRL_B, 8'h00);
    wr(OFF_CTRL_A, 8'h00);
    // ten undivided ticks from zero pass both compare values
    wr(OFF_CMP_A, 8'h03);
    wr(OFF_CMP_B, 8'h05);
    wr(OFF_COUNT, 8'h00);
    wr(OFF_CTRL_B, 8'(CS_DIV1));
    repeat (8) @(posedge clk_sys);
    wr(OFF_CTRL_B, 8'(CS_STOP));
    rd(OFF_COUNT, 8'h0A);
    rd(OFF_FLAGS, 8'h18);
    `CHK(irq_req, 3'b011)
    // global enable gates the requests
    cpu_irq_enable <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(irq_req, 3'b000)
    cpu_irq_enable <= 1'b1;
    repeat (2) @(posedge clk_sys);
    // handler entry clears only its own flag
    vector_ack <= 3'b001;
    @(posedge clk_sys);
    vector_ack <= 3'b000;
    rd(OFF_FLAGS, 8'h08);
    `CHK(irq_req, 3'b010)
    wr(OFF_FLAGS, 8'h00);
    rd(OFF_FLAGS, 8'h08);
    wr(OFF_FLAGS, 8'h08);
    rd(OFF_FLAGS, 8'h00);
    // four ticks from 0xFD: first match lost after the counter write,
    // then match b at 0xFE and wrap at 0xFF
    wr(OFF_CMP_A, 8'hFD);
    wr(OFF_CMP_B, 8'hFE);
    wr(OFF_COUNT, 8'hFD);
    wr(OFF_CTRL_B, 8'(CS_DIV1));
    repeat (2) @(posedge clk_sys);
    wr(OFF_CTRL_B, 8'(CS_STOP));
    rd(OFF_COUNT, 8'h01);
    rd(OFF_FLAGS, 8'h0A);
    `CHK(irq_req, 3'b110)
    wr(OFF_FLAGS, 8'h1A);
    rd(OFF_FLAGS, 8'h00);
    // any window of three periods holds exactly three taps,
    // whatever phase the free prescaler is in
    for (int i = 0; i < 5; i++)
    begin
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CTRL_B, 8'(i + 1));
      repeat (3 * div[i] - 2) @(posedge clk_sys);
      wr(OFF_CTRL_B, 8'(CS_STOP));
      rd(OFF_COUNT, 8'h03);
    end
    // three pin pulses give three counts on the chosen edge only
    for (int k = 0; k < 2; k++)
    begin
      wr(OFF_COUNT, 8'h00);
      wr(OFF_CTRL_B, (k == 0) ? 8'(CS_EXT_RISE) : 8'(CS_EXT_FALL));
      repeat (3)
      begin
        ext_count_pin <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ext_count_pin <= 1'b0;
        repeat (4) @(posedge clk_sys);
      end
      // let the synchroniser drain before stopping
      repeat (6) @(posedge clk_sys);
      wr(OFF_CTRL_B, 8'(CS_STOP));
      rd(OFF_COUNT, 8'h03);
    end
    // write then read back to back; read data stands one cycle only
    bus_req <= '{we: 1'b1, re: 1'b0, addr: OFF_COUNT, wdata: 8'h5A};
    @(posedge clk_sys);
    rd(OFF_COUNT, 8'h5A);
    @(negedge clk_sys);
    `CHK(rd_data, 8'h00)
    @(posedge clk_sys);
    // fast pwm, top from compare a: b clears on match, sets at bottom;
    // the clock enable drops for four cycles and freezes the count
    wr(OFF_CMP_A, 8'h05);
    wr(OFF_CMP_B, 8'h02);
    wr(OFF_COUNT, 8'h00);
    wr(OFF_CTRL_A, 8'h23);
    `CHK(wave_oe, 2'h2)
    wr(OFF_CTRL_B, 8'h09);
    clk_en <= 1'b0;
    repeat (4) @(posedge clk_sys);
    clk_en <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wr(OFF_CTRL_B, 8'h08);
    rd(OFF_COUNT, 8'h05);
    rd(OFF_FLAGS, 8'h08);
    `CHK(wave_out, 2'h0)
    // two more ticks: top clears the count, wraps, match a, b set again
    wr(OFF_CTRL_B, 8'h09);
    wr(OFF_CTRL_B, 8'h08);
    rd(OFF_COUNT, 8'h01);
    rd(OFF_FLAGS, 8'h1A);
    `CHK({irq_req, wave_out}, 5'h1E)
    stop_test();
  end

endmodule
